//--- hw/cffr_core.sv
// flag, mask and charger response logic with an AXI4-Lite register slave
`timescale 1ns/1ns
module cffr_core
    import cffr_pkg::*;
(
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET,
    // AXI4-Lite write address and data
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [ADDR_W-1:0] AWADDR,
    input wire logic WVALID,
    output logic WREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    // AXI4-Lite write response
    output logic BVALID,
    input wire logic BREADY,
    output logic [1:0] BRESP,
    // AXI4-Lite read
    input wire logic ARVALID,
    output logic ARREADY,
    input wire logic [ADDR_W-1:0] ARADDR,
    output logic RVALID,
    input wire logic RREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    // analog condition levels
    input wire logic CV_PHASE,
    input wire logic TERMINATION,
    input wire logic INPUT_CURRENT_LIMIT,
    input wire logic SYSTEM_DROOP_LOOP,
    input wire logic INPUT_VOLTAGE_LOOP,
    input wire logic DIE_THERMAL_FOLDBACK,
    input wire logic INPUT_GOOD,
    input wire logic INPUT_OVERVOLTAGE,
    input wire logic BATTERY_OVERCURRENT,
    input wire logic BATTERY_UNDERVOLTAGE,
    input wire logic THERMISTOR_COLD,
    input wire logic THERMISTOR_COOL,
    input wire logic RECHARGE_LEVEL,
    // charger and rail controls
    output logic CHARGE_EN,
    output logic CHARGE_REDUCE,
    output logic TIMER_RESET,
    output logic TIMER_PAUSE,
    output logic TIMER_DOUBLE,
    output logic RAIL_FROM_INPUT,
    output logic RAIL_FROM_BATTERY,
    output logic BATTERY_DISCONNECT,
    // open-drain interrupt pin
    output logic INT_N_O,
    output logic INT_N_OE_N
);
    // ****************************************
    // condition capture and edges
    // ****************************************
    logic [NCOND:0] pins;
    logic [NCOND:0] sync_q;
    logic [NCOND-1:0] cond;
    logic [NCOND-1:0] cond_q;
    logic [NCOND-1:0] edges;
    logic recharge;

    assign pins = {RECHARGE_LEVEL, THERMISTOR_COOL, THERMISTOR_COLD,
        BATTERY_UNDERVOLTAGE, BATTERY_OVERCURRENT, INPUT_OVERVOLTAGE,
        INPUT_GOOD, DIE_THERMAL_FOLDBACK, INPUT_VOLTAGE_LOOP,
        SYSTEM_DROOP_LOOP, INPUT_CURRENT_LIMIT, TERMINATION, CV_PHASE};

    cffr_sync #(.W(NCOND + 1)) u_sync (
        .clk(SYS_CLK),
        .rst(RESET),
        .d(pins),
        .q(sync_q)
    );
    assign cond = sync_q[NCOND-1:0];
    assign recharge = sync_q[NCOND];

    // rising edges everywhere, except input good which reports both ways
    assign edges = (cond & ~cond_q)
        | ({{(NCOND-1){1'b0}}, 1'b0} | (12'h001 << B_GOOD) & (cond ^ cond_q));

    // ****************************************
    // register bus
    // ****************************************
    function automatic logic [2:0] reg_idx(input logic [ADDR_W-1:0] a);
        if (a == A_FLAGS) reg_idx = {1'b1, R_FLAGS};
        else if (a == A_STATUS) reg_idx = {1'b1, R_STATUS};
        else if (a == A_MASK) reg_idx = {1'b1, R_MASK};
        else if (a == A_CTRL) reg_idx = {1'b1, R_CTRL};
        else reg_idx = 3'h0;
    endfunction

    logic [NCOND-1:0] flags;
    logic [NCOND-1:0] mask;
    logic [3:0] ctrl;
    logic aw_hold;
    logic w_hold;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic wr_do;
    logic next_aw_hold;
    logic next_w_hold;
    logic next_bvalid;
    logic next_rvalid;
    logic [2:0] wr_sel;
    logic [2:0] rd_sel;
    logic [31:0] rd_word;
    logic rd_clr;
    logic wr_mask;
    logic wr_ctrl;

    assign aw_hs = AWVALID && AWREADY;
    assign w_hs = WVALID && WREADY;
    assign ar_hs = ARVALID && ARREADY;
    assign wr_do = aw_hold && w_hold && !BVALID;
    assign next_aw_hold = wr_do ? 1'b0 : (aw_hold || aw_hs);
    assign next_w_hold = wr_do ? 1'b0 : (w_hold || w_hs);
    assign next_bvalid = wr_do || (BVALID && !BREADY);
    assign next_rvalid = ar_hs || (RVALID && !RREADY);
    assign wr_sel = reg_idx(aw_addr);
    assign rd_sel = reg_idx(ARADDR);
    assign wr_mask = wr_do && wr_sel == {1'b1, R_MASK} && w_strb[0];
    assign wr_ctrl = wr_do && wr_sel == {1'b1, R_CTRL} && w_strb[0];
    // a read of the flags clears exactly the bits it returned
    assign rd_clr = ar_hs && rd_sel == {1'b1, R_FLAGS};

    always_comb begin
        rd_word = 32'h00000000;
        if (rd_sel == {1'b1, R_FLAGS}) rd_word[NCOND-1:0] = flags;
        else if (rd_sel == {1'b1, R_STATUS}) rd_word[NCOND-1:0] = cond;
        else if (rd_sel == {1'b1, R_MASK}) rd_word[NCOND-1:0] = mask;
        else if (rd_sel == {1'b1, R_CTRL}) rd_word[3:0] = ctrl;
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            AWREADY <= 1'b0;
            WREADY <= 1'b0;
            BVALID <= 1'b0;
            BRESP <= RESP_OKAY;
        end else begin
            aw_hold <= next_aw_hold;
            w_hold <= next_w_hold;
            AWREADY <= !next_aw_hold && !next_bvalid;
            WREADY <= !next_w_hold && !next_bvalid;
            BVALID <= next_bvalid;
            if (aw_hs) aw_addr <= AWADDR;
            if (w_hs) begin
                w_data <= WDATA;
                w_strb <= WSTRB;
            end
            if (wr_do) BRESP <= wr_sel[2] ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            ARREADY <= 1'b0;
            RVALID <= 1'b0;
            RDATA <= 32'h00000000;
            RRESP <= RESP_OKAY;
        end else begin
            ARREADY <= !next_rvalid;
            RVALID <= next_rvalid;
            if (ar_hs) begin
                RDATA <= rd_word;
                RRESP <= rd_sel[2] ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ****************************************
    // flags, mask and interrupt request
    // ****************************************
    logic int_req;
    logic [NCOND-1:0] clr_bits;
    assign clr_bits = rd_clr ? flags : 12'h000;

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            cond_q <= 12'h000;
            flags <= 12'h000;
            mask <= MASK_RST;
            ctrl <= CTRL_RST;
            int_req <= 1'b0;
        end else begin
            cond_q <= cond;
            // a new event in the clearing cycle survives
            flags <= (flags & ~clr_bits) | edges;
            // only an edge seen while unmasked asks for a pulse
            int_req <= |(edges & ~mask);
            if (wr_mask) mask <= w_data[NCOND-1:0];
            if (wr_ctrl) ctrl <= w_data[3:0];
        end
    end

    cffr_pulse u_pulse (
        .clk(SYS_CLK),
        .rst(RESET),
        .start(int_req),
        .int_n_o(INT_N_O),
        .int_n_oe_n(INT_N_OE_N)
    );

    // ****************************************
    // charger, timer and rail response
    // ****************************************
    logic done_pause;
    logic ce_q;
    logic release_pause;
    logic reduce;
    logic next_charge;
    logic rail_in;
    assign release_pause = edges[B_GOOD] || (ctrl[C_CE] != ce_q) || recharge;
    assign reduce = cond[B_ILIM] || cond[B_DROOP] || cond[B_VLOOP]
        || cond[B_THERM] || cond[B_COOL];
    // constant voltage and under-voltage leave charging alone
    assign next_charge = ctrl[C_CE] && cond[B_GOOD] && !done_pause
        && !cond[B_OVP] && !cond[B_OCP] && !cond[B_COLD];
    assign rail_in = cond[B_GOOD] && ctrl[C_SEL_HI:C_SEL_LO] == 2'b00
        && !cond[B_OVP];

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            done_pause <= 1'b0;
            ce_q <= CTRL_RST[C_CE];
            CHARGE_EN <= 1'b0;
            CHARGE_REDUCE <= 1'b0;
            TIMER_RESET <= 1'b0;
            TIMER_PAUSE <= 1'b0;
            TIMER_DOUBLE <= 1'b0;
            RAIL_FROM_INPUT <= 1'b0;
            RAIL_FROM_BATTERY <= 1'b0;
            BATTERY_DISCONNECT <= 1'b0;
        end else begin
            ce_q <= ctrl[C_CE];
            if (edges[B_DONE]) done_pause <= 1'b1;
            else if (release_pause) done_pause <= 1'b0;
            CHARGE_EN <= next_charge;
            CHARGE_REDUCE <= reduce;
            TIMER_RESET <= edges[B_DONE] || edges[B_GOOD] || edges[B_OVP];
            TIMER_PAUSE <= cond[B_COLD];
            TIMER_DOUBLE <= ctrl[C_DBL] && reduce;
            RAIL_FROM_INPUT <= rail_in;
            RAIL_FROM_BATTERY <= !rail_in && !cond[B_OCP];
            BATTERY_DISCONNECT <= cond[B_OCP];
        end
    end

    // ****************************************
    // checks
    // ****************************************
    sequence done_seen;
        $rose(cond[B_DONE]);
    endsequence
    // a legal release in the cycle after the flag lets charging resume, so only
    // a termination that is not released at once must show charging held off
    sequence stays_paused;
        !release_pause;
    endsequence

    cv_flag_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        $rose(cond[B_CV]) |=> flags[B_CV])
        else $error("constant voltage flag not set");
    done_pause_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        done_seen ##1 stays_paused |=> !CHARGE_EN)
        else $error("charging not paused after termination");
    loop_reduce_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        cond[B_ILIM] && ctrl[C_DBL] |=> CHARGE_REDUCE && TIMER_DOUBLE)
        else $error("loop did not reduce current");
    good_edge_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        $fell(cond[B_GOOD]) |=> flags[B_GOOD] && TIMER_RESET)
        else $error("input good fall not flagged");
    good_low_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        !cond[B_GOOD] |=> !CHARGE_EN)
        else $error("charging with input not good");
    rail_input_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        cond[B_GOOD] && !cond[B_OVP] && ctrl[3:2] == 2'b00 |=> RAIL_FROM_INPUT)
        else $error("rail not fed from input");
    ovp_resp_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        cond[B_OVP] && !cond[B_OCP] |=> !CHARGE_EN && RAIL_FROM_BATTERY)
        else $error("over-voltage response wrong");
    ocp_resp_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        cond[B_OCP] |=> BATTERY_DISCONNECT && !CHARGE_EN && !RAIL_FROM_BATTERY)
        else $error("over-current response wrong");
    uvlo_flag_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        $rose(cond[B_UVLO]) |=> flags[B_UVLO] && !TIMER_RESET)
        else $error("under-voltage flag not set");
    cold_pause_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        cond[B_COLD] |=> TIMER_PAUSE && !CHARGE_EN)
        else $error("cold did not pause");
    cool_double_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        cond[B_COOL] && ctrl[C_DBL] |=> CHARGE_REDUCE && TIMER_DOUBLE)
        else $error("cool response wrong");
    masked_quiet_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (edges & ~mask) == 12'h000 |=> !int_req ##1 $stable(INT_N_OE_N) || INT_N_OE_N)
        else $error("masked event raised interrupt");
    read_clear_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        rd_clr && edges == 12'h000 |=> flags == 12'h000)
        else $error("flags not cleared by read");
endmodule

//--- hw/cffr_pulse.sv
// fixed-length low pulse on the open-drain interrupt pin
`timescale 1ns/1ns
module cffr_pulse
    import cffr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // request
    input wire logic start,
    // pin
    output logic int_n_o,
    output logic int_n_oe_n
);
    logic [INT_CW-1:0] cnt;
    logic active;
    // a new event mid-pulse restarts the count, stretching the one pulse to full length after it
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt <= '0;
            active <= 1'b0;
            int_n_oe_n <= 1'b1;
            int_n_o <= 1'b0;
        end else begin
            int_n_o <= 1'b0;
            if (start) begin
                cnt <= '0;
                active <= 1'b1;
                int_n_oe_n <= 1'b0;
            end else if (active && cnt == INT_LAST) begin
                active <= 1'b0;
                int_n_oe_n <= 1'b1;
            end else if (active) begin
                cnt <= cnt + 11'h001;
            end
        end
    end
    pulse_hold_a: assert property (@(posedge clk) disable iff (rst)
        start |=> (!int_n_oe_n) [*8])
        else $error("interrupt pulse ended early");
    pulse_end_a: assert property (@(posedge clk) disable iff (rst)
        $rose(int_n_oe_n) |-> $past(cnt) == INT_LAST)
        else $error("interrupt pulse length wrong");
endmodule

//--- hw/cffr_sync.sv
// two-stage synchroniser for a vector of pin levels
`timescale 1ns/1ns
module cffr_sync #(
    parameter int W = 13
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    always_ff @(posedge clk) begin
        if (rst) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

//--- shared/cffr_pkg.sv
// constants for the charger fault flag and interrupt block
// What this block does
// - flag and interrupt on entering constant voltage
// - termination flags, pauses charging, resets safety timer
// - regulation loop flags, reduce current, optional doubling
// - input good change flags on both edges
// - input good low disables charging, timer reset
// - over-voltage flags, pauses charge, rail from battery
// - over-current flags, disables charge, disconnects battery
// - under-voltage flags, charging and timer unaffected
// - cold flags, pauses charging and safety timer
// - cool flags, reduced current, optional doubling
// - interrupt is fixed low pulse on open drain
// - masked conditions never pulse, even after unmasking
package cffr_pkg;
    // ****************************************
    // condition and flag bit positions
    // ****************************************
    localparam int NCOND = 12;
    localparam int B_CV = 0;
    localparam int B_DONE = 1;
    localparam int B_ILIM = 2;
    localparam int B_DROOP = 3;
    localparam int B_VLOOP = 4;
    localparam int B_THERM = 5;
    localparam int B_GOOD = 6;
    localparam int B_OVP = 7;
    localparam int B_OCP = 8;
    localparam int B_UVLO = 9;
    localparam int B_COLD = 10;
    localparam int B_COOL = 11;
    // ****************************************
    // register map, byte addresses
    // ****************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] A_FLAGS = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_MASK = 8'h08;
    localparam logic [7:0] A_CTRL = 8'h0C;
    localparam logic [11:0] MASK_RST = 12'h000;
    // control fields
    localparam int C_CE = 0;
    localparam int C_DBL = 1;
    localparam int C_SEL_LO = 2;
    localparam int C_SEL_HI = 3;
    localparam logic [3:0] CTRL_RST = 4'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int INT_PULSE_US = 128;
    localparam int INT_CYC = (INT_PULSE_US * 1000) / CLK_PERIOD_NS;
    localparam int INT_CW = 11;
    localparam logic [10:0] INT_LAST = 11'(INT_CYC - 1);
    typedef enum logic [1:0] {
        R_FLAGS = 2'b00,
        R_STATUS = 2'b01,
        R_MASK = 2'b10,
        R_CTRL = 2'b11
    } cffr_reg_e;
endpackage

//--- sim/cffr_core_tb.sv
// self-checking bench for the charger flag and interrupt block
`timescale 1ns/1ns
module cffr_core_tb
    import cffr_pkg::*;
;
    logic SYS_CLK = 1'b0;
    logic RESET = 1'b1;
    logic [11:0] cond = 12'h040;
    logic rch = 1'b0;
    wire logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
    wire logic [7:0] AWADDR, ARADDR;
    wire logic [31:0] WDATA, RDATA;
    wire logic [3:0] WSTRB;
    wire logic [1:0] BRESP, RRESP;
    wire logic CHARGE_EN, CHARGE_REDUCE, TIMER_RESET, TIMER_PAUSE, TIMER_DOUBLE;
    wire logic RAIL_FROM_INPUT, RAIL_FROM_BATTERY, BATTERY_DISCONNECT, INT_N_O, INT_N_OE_N;
    wire logic [6:0] outs = {CHARGE_EN, CHARGE_REDUCE, TIMER_PAUSE, TIMER_DOUBLE,
        RAIL_FROM_INPUT, RAIL_FROM_BATTERY, BATTERY_DISCONNECT};
    localparam logic [6:0] BASE = 7'h44;
    int errors = 0;
    int n_compared = 0;
    int n_treset = 0;

    cffr_core i_cffr_core (.SYS_CLK(SYS_CLK), .RESET(RESET),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR), .WVALID(WVALID),
        .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB), .BVALID(BVALID), .BREADY(BREADY),
        .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
        .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
        .CV_PHASE(cond[B_CV]), .TERMINATION(cond[B_DONE]), .INPUT_CURRENT_LIMIT(cond[B_ILIM]),
        .SYSTEM_DROOP_LOOP(cond[B_DROOP]), .INPUT_VOLTAGE_LOOP(cond[B_VLOOP]),
        .DIE_THERMAL_FOLDBACK(cond[B_THERM]), .INPUT_GOOD(cond[B_GOOD]),
        .INPUT_OVERVOLTAGE(cond[B_OVP]), .BATTERY_OVERCURRENT(cond[B_OCP]),
        .BATTERY_UNDERVOLTAGE(cond[B_UVLO]), .THERMISTOR_COLD(cond[B_COLD]),
        .THERMISTOR_COOL(cond[B_COOL]), .RECHARGE_LEVEL(rch), .CHARGE_EN(CHARGE_EN),
        .CHARGE_REDUCE(CHARGE_REDUCE), .TIMER_RESET(TIMER_RESET), .TIMER_PAUSE(TIMER_PAUSE),
        .TIMER_DOUBLE(TIMER_DOUBLE), .RAIL_FROM_INPUT(RAIL_FROM_INPUT),
        .RAIL_FROM_BATTERY(RAIL_FROM_BATTERY), .BATTERY_DISCONNECT(BATTERY_DISCONNECT),
        .INT_N_O(INT_N_O), .INT_N_OE_N(INT_N_OE_N));

    cffr_host i_cffr_host (.clk(SYS_CLK), .awvalid(AWVALID), .awready(AWREADY),
        .awaddr(AWADDR), .wvalid(WVALID), .wready(WREADY), .wdata(WDATA), .wstrb(WSTRB),
        .bvalid(BVALID), .bready(BREADY), .bresp(BRESP), .arvalid(ARVALID),
        .arready(ARREADY), .araddr(ARADDR), .rvalid(RVALID), .rready(RREADY),
        .rdata(RDATA), .rresp(RRESP), .int_n_o(INT_N_O), .int_n_oe_n(INT_N_OE_N));

    always #50 SYS_CLK = ~SYS_CLK;

    always @(posedge SYS_CLK) begin
        if (TIMER_RESET === 1'b1) begin
            n_treset <= n_treset + 1;
        end
    end

    // ****************************************
    // checking helpers
    // ****************************************
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        i_cffr_host.rd(a, d, r);
        cmp(d, e);
        cmp(r, RESP_OKAY);
    endtask

    // one condition edge: a pulse long enough to finish, then outputs and flags
    task automatic trig(input int b, input logic v, input int np, input logic [6:0] eo,
        input int nt);
        int p;
        int t;
        p = i_cffr_host.pulses;
        t = n_treset;
        @(posedge SYS_CLK);
        cond[b] <= v;
        repeat (1400) @(posedge SYS_CLK);
        cmp(i_cffr_host.pulses - p, np);
        if (np != 0) cmp(i_cffr_host.width, INT_CYC);
        cmp(outs, eo);
        cmp(n_treset - t, nt);
        rdc(A_FLAGS, 32'h1 << b);
        rdc(A_FLAGS, 32'h0);
    endtask

    task automatic clr(input int b);
        @(posedge SYS_CLK);
        cond[b] <= 1'b0;
        repeat (8) @(posedge SYS_CLK);
    endtask

    task automatic final_report();
        if (errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int p;
        repeat (4) @(posedge SYS_CLK);
        RESET <= 1'b0;
        // let any start-up input good edge finish, then drop its flag
        repeat (1400) @(posedge SYS_CLK);
        cmp(outs, BASE);
        i_cffr_host.rd(A_FLAGS, d, r);
        rdc(A_CTRL, 32'h1);
        rdc(A_MASK, 32'h0);
        rdc(A_STATUS, 32'h1 << B_GOOD);
        i_cffr_host.rd(8'h10, d, r);
        cmp(r, RESP_SLVERR);
        i_cffr_host.wr(A_FLAGS, 32'hFFF, r);
        cmp(r, RESP_OKAY);
        i_cffr_host.wr(8'h10, 32'h1, r);
        cmp(r, RESP_SLVERR);
        rdc(A_FLAGS, 32'h0);
        trig(B_CV, 1'b1, 1, BASE, 0);
        clr(B_CV);
        trig(B_DONE, 1'b1, 1, 7'h04, 1);
        @(posedge SYS_CLK);
        rch <= 1'b1;
        cond[B_DONE] <= 1'b0;
        repeat (8) @(posedge SYS_CLK);
        cmp(outs, BASE);
        rch <= 1'b0;
        i_cffr_host.wr(A_CTRL, 32'h3, r);
        for (int b = B_ILIM; b <= B_THERM; b++) begin
            trig(b, 1'b1, 1, 7'h6C, 0);
            clr(b);
        end
        trig(B_COOL, 1'b1, 1, 7'h6C, 0);
        clr(B_COOL);
        i_cffr_host.wr(A_CTRL, 32'h1, r);
        trig(B_GOOD, 1'b0, 1, 7'h02, 1);
        trig(B_GOOD, 1'b1, 1, BASE, 1);
        i_cffr_host.wr(A_CTRL, 32'h5, r);
        repeat (4) @(posedge SYS_CLK);
        cmp(outs, 7'h42);
        i_cffr_host.wr(A_CTRL, 32'h1, r);
        trig(B_OVP, 1'b1, 1, 7'h02, 1);
        clr(B_OVP);
        trig(B_OCP, 1'b1, 1, 7'h05, 0);
        clr(B_OCP);
        trig(B_UVLO, 1'b1, 1, BASE, 0);
        clr(B_UVLO);
        trig(B_COLD, 1'b1, 1, 7'h14, 0);
        clr(B_COLD);
        i_cffr_host.wr(A_MASK, 32'h1 << B_CV, r);
        rdc(A_MASK, 32'h1 << B_CV);
        trig(B_CV, 1'b1, 0, BASE, 0);
        p = i_cffr_host.pulses;
        i_cffr_host.wr(A_MASK, 32'h0, r);
        repeat (1400) @(posedge SYS_CLK);
        cmp(i_cffr_host.pulses, p);
        final_report();
    end

    // watchdog sized well past the roughly 23000 cycles the scenarios need
    initial begin
        repeat (60000) @(posedge SYS_CLK);
        errors++;
        final_report();
    end
endmodule

//--- sim/cffr_host.sv
// host model: AXI4-Lite master tasks and the pulled-up interrupt line
`timescale 1ns/1ns
module cffr_host
    import cffr_pkg::*;
(
    // clock
    input wire logic clk,
    // AXI4-Lite master side
    output logic awvalid,
    input wire logic awready,
    output logic [ADDR_W-1:0] awaddr,
    output logic wvalid,
    input wire logic wready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    input wire logic bvalid,
    output logic bready,
    input wire logic [1:0] bresp,
    output logic arvalid,
    input wire logic arready,
    output logic [ADDR_W-1:0] araddr,
    input wire logic rvalid,
    output logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    // open-drain interrupt line
    input wire logic int_n_o,
    input wire logic int_n_oe_n
);
    // the pull-up holds the line high whenever the block lets go of it
    wire logic int_line = int_n_oe_n ? 1'b1 : int_n_o;
    int low_cnt = 0;
    int pulses = 0;
    int width = 0;

    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hF;
    end

    always @(posedge clk) begin
        if (int_line === 1'b0) begin
            low_cnt <= low_cnt + 1;
        end else if (low_cnt != 0) begin
            width <= low_cnt;
            pulses <= pulses + 1;
            low_cnt <= 0;
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ad;
        logic dd;
        ad = 1'b0;
        dd = 1'b0;
        @(posedge clk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        while (!(ad && dd)) begin
            @(posedge clk);
            if (!ad && awready) begin
                ad = 1'b1;
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (!dd && wready) begin
                dd = 1'b1;
                wvalid <= 1'b0;
                wdata <= ~d;
            end
        end
        while (!bvalid) @(posedge clk);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        araddr <= ~a;
        while (!rvalid) @(posedge clk);
        // reading the flags is what clears them
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
endmodule
